// ### rtl/smag_host_ctrl.sv
/*
  Host-side controller driving a stacked static RAM and flash package over shared
  address and data pins. Assumes the data bus is resolved outside from o_data_oe,
  and that i_flash_supply_ok comes from an asynchronous supply monitor.
*/
`timescale 1ns/1ps

module smag_host_ctrl
  import smag_pkg::*;
#(
  parameter int DW = 16,
  parameter int AW = 20
) (
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_reset_n,
  // User request port
  input  wire logic          i_req,
  input  wire logic [1:0]    i_op,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [DW-1:0] i_old_data,
  input  wire logic          i_unlock_all,
  input  wire logic          i_boot_lock,
  output logic               o_ready,
  output logic               o_done,
  output logic [DW-1:0]      o_rdata,
  // Supply monitor
  input  wire logic          i_flash_supply_ok,
  // Memory pins
  output logic [AW-1:0]      o_addr,
  input  wire logic [DW-1:0] i_data,
  output logic [DW-1:0]      o_data,
  output logic               o_data_oe,
  output logic               o_sram_select_low_n,
  output logic               o_sram_select_high,
  output logic               o_sram_write_strobe_n,
  output logic               o_sram_output_gate_n,
  output logic               o_flash_select_n,
  output logic               o_flash_write_strobe_n,
  output logic               o_flash_output_gate_n,
  output logic               o_flash_reset_powerdown_n,
  output logic               o_flash_unlock_hv,
  output logic               o_flash_boot_guard_n,
  output logic               o_program_supply_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers

  logic          rst_s1_r;
  logic          rst_n;
  logic          ok_s1_r;
  logic          ok_s2_r;
  logic [DW-1:0] dat_s1_r;
  logic [DW-1:0] dat_s2_r;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ok_s1_r  <= 1'b0;
      ok_s2_r  <= 1'b0;
      dat_s1_r <= '0;
      dat_s2_r <= '0;
    end else begin
      ok_s1_r  <= i_flash_supply_ok;
      ok_s2_r  <= ok_s1_r;
      dat_s1_r <= i_data;
      dat_s2_r <= dat_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash power-up sequencing

  logic [CNT_W-1:0] pwr_cnt_r;
  logic [CNT_W-1:0] recov_cnt_r;
  logic             rp_n_r;
  logic             flash_ready_r;

  // Supply loss drops reset at once so the flash stays write-locked
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_cnt_r     <= '0;
      recov_cnt_r   <= '0;
      rp_n_r        <= 1'b0;
      flash_ready_r <= 1'b0;
    end else if (!ok_s2_r) begin
      pwr_cnt_r     <= '0;
      recov_cnt_r   <= '0;
      rp_n_r        <= 1'b0;
      flash_ready_r <= 1'b0;
    end else if (pwr_cnt_r < CNT_W'(PWRUP_CYC)) begin
      pwr_cnt_r <= pwr_cnt_r + 1'b1;
    end else begin
      rp_n_r <= 1'b1;
      if (recov_cnt_r < CNT_W'(RECOV_CYC))
        recov_cnt_r <= recov_cnt_r + 1'b1;
      else
        flash_ready_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  smag_state_e      state_r;
  smag_op_e         op_r;
  logic [CNT_W-1:0] cnt_r;
  logic             is_wr;
  logic             is_sram;

  assign is_wr   = (op_r == OP_SRAM_WR) || (op_r == OP_FLASH_WR);
  assign is_sram = (op_r == OP_SRAM_RD) || (op_r == OP_SRAM_WR);
  assign o_ready = flash_ready_r && (state_r == ST_IDLE);

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r                <= ST_IDLE;
      op_r                   <= OP_SRAM_RD;
      cnt_r                  <= '0;
      o_addr                 <= '0;
      o_data                 <= '0;
      o_data_oe              <= 1'b0;
      o_rdata                <= '0;
      o_done                 <= 1'b0;
      o_sram_select_low_n    <= 1'b1;
      o_sram_select_high     <= 1'b0;
      o_sram_write_strobe_n  <= 1'b1;
      o_sram_output_gate_n   <= 1'b1;
      o_flash_select_n       <= 1'b1;
      o_flash_write_strobe_n <= 1'b1;
      o_flash_output_gate_n  <= 1'b1;
      o_flash_unlock_hv      <= 1'b0;
      o_program_supply_en    <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (i_req && o_ready) begin
            op_r   <= smag_op_e'(i_op);
            o_addr <= i_addr;
            // Ones on bits already zero, zeros only where a one must clear
            if (smag_op_e'(i_op) == OP_FLASH_WR)
              o_data <= ~(i_old_data & ~i_wdata);
            else
              o_data <= i_wdata;
            // Program supply and unlock voltage set up a full cycle ahead
            o_program_supply_en <= (smag_op_e'(i_op) == OP_FLASH_WR);
            o_flash_unlock_hv   <= (smag_op_e'(i_op) == OP_FLASH_WR) && i_unlock_all;
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Previous selects were dropped at least three cycles ago, so no overlap
          if (is_sram) begin
            o_sram_select_low_n <= 1'b0;
            o_sram_select_high  <= 1'b1;
            // Write strobe falls with selection so SRAM outputs never turn on during a write
            if (is_wr)
              o_sram_write_strobe_n <= 1'b0;
            else
              o_sram_output_gate_n  <= 1'b0;
            cnt_r <= is_wr ? CNT_W'(SRAM_WR_CYC - 1) : CNT_W'(SRAM_RD_CYC - 1);
          end else begin
            o_flash_select_n <= 1'b0;
            if (is_wr)
              o_flash_write_strobe_n <= 1'b0;
            else
              o_flash_output_gate_n  <= 1'b0;
            cnt_r <= is_wr ? CNT_W'(FLASH_WR_CYC - 1) : CNT_W'(FLASH_RD_CYC - 1);
          end
          state_r <= ST_ACT;
        end
        ST_ACT: begin
          // Data goes out one cycle after the strobe, once the bus is free
          if (is_wr)
            o_data_oe <= 1'b1;
          if (cnt_r == '0) begin
            // All selects and strobes close in one edge
            o_sram_select_low_n    <= 1'b1;
            o_sram_select_high     <= 1'b0;
            o_sram_write_strobe_n  <= 1'b1;
            o_sram_output_gate_n   <= 1'b1;
            o_flash_select_n       <= 1'b1;
            o_flash_write_strobe_n <= 1'b1;
            o_flash_output_gate_n  <= 1'b1;
            if (!is_wr)
              o_rdata <= dat_s2_r;
            state_r <= ST_END;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_END: begin
          o_data_oe           <= 1'b0;
          o_program_supply_en <= 1'b0;
          o_flash_unlock_hv   <= 1'b0;
          o_done              <= 1'b1;
          state_r             <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Boot blocks are locked in reset and while the user holds i_boot_lock, unless i_unlock_all raises the unlock voltage; open otherwise
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n)
      o_flash_boot_guard_n <= 1'b0;
    else
      o_flash_boot_guard_n <= !i_boot_lock;
  end

  assign o_flash_reset_powerdown_n = rp_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic          sram_sel;
  logic [DW-1:0] old_chk_r;
  logic [DW-1:0] new_chk_r;

  assign sram_sel = !o_sram_select_low_n && o_sram_select_high;

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      old_chk_r <= '0;
      new_chk_r <= '0;
    end else if (i_req && o_ready) begin
      old_chk_r <= i_old_data;
      new_chk_r <= i_wdata;
    end
  end

  sequence s_sram_wr_open;
    $fell(o_sram_write_strobe_n) && sram_sel;
  endsequence

  sequence s_sram_wr_hold_close;
    (sram_sel && !o_sram_write_strobe_n) [*3] ##1 (o_sram_write_strobe_n && !sram_sel);
  endsequence

  a_no_dual_select: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    !(sram_sel && !o_flash_select_n))
    else $error("SRAM and flash selected together");

  a_drive_after_strobe: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    $rose(o_data_oe) |-> $past(!o_sram_write_strobe_n || !o_flash_write_strobe_n)
      && (!o_sram_write_strobe_n || !o_flash_write_strobe_n))
    else $error("Data driven before write strobe");

  a_powerup_hold: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    $rose(o_flash_reset_powerdown_n) |->
      $past(ok_s2_r, 1) && $past(ok_s2_r, 2) && $past(ok_s2_r, 3))
    else $error("Flash reset released too early");

  a_program_pattern: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (o_data_oe && !o_flash_write_strobe_n) |-> o_data == ~(old_chk_r & ~new_chk_r))
    else $error("Flash program pattern wrong");

  a_sram_write_window: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    s_sram_wr_open |-> s_sram_wr_hold_close)
    else $error("SRAM write window malformed");

  a_gate_no_drive: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (!o_sram_output_gate_n || !o_flash_output_gate_n) |-> !o_data_oe)
    else $error("Host drives bus during read");

endmodule

// ### rtl/smag_pkg.sv
/*
  Constants for the host controller of a stacked static RAM plus flash package.
  Assumes a 50 ns core clock; every cycle count is derived from a time in ns.
*/
package smag_pkg;

  // Core clock period
  localparam int CLK_NS        = 50;

  // Pin timing figures in ns
  localparam int SRAM_WP_NS    = 55;
  localparam int SRAM_ACC_NS   = 85;
  localparam int FLASH_WP_NS   = 50;
  localparam int FLASH_ACC_NS  = 100;
  localparam int PWRUP_HOLD_NS = 100;
  localparam int RECOV_NS      = 10000;

  // Least times round up; the power-up hold must exceed its figure
  localparam int SRAM_WP_CYC   = (SRAM_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SRAM_ACC_CYC  = (SRAM_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLASH_WP_CYC  = (FLASH_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLASH_ACC_CYC = (FLASH_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWRUP_CYC     = PWRUP_HOLD_NS / CLK_NS + 1;
  localparam int RECOV_CYC     = (RECOV_NS + CLK_NS - 1) / CLK_NS;

  // Input synchroniser depth, also the read capture lag
  localparam int SYNC_STAGES   = 2;

  // Strobe-active lengths in cycles; writes add one cycle for data turnaround
  localparam int SRAM_WR_CYC   = SRAM_WP_CYC + 1;
  localparam int SRAM_RD_CYC   = SRAM_ACC_CYC + SYNC_STAGES;
  localparam int FLASH_WR_CYC  = FLASH_WP_CYC + 1;
  localparam int FLASH_RD_CYC  = FLASH_ACC_CYC + SYNC_STAGES;

  localparam int CNT_W         = 8;

  // Operation codes on the user port
  typedef enum logic [1:0] {
    OP_SRAM_RD  = 2'h0,
    OP_SRAM_WR  = 2'h1,
    OP_FLASH_RD = 2'h2,
    OP_FLASH_WR = 2'h3
  } smag_op_e;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SETUP = 4'h2,
    ST_ACT   = 4'h4,
    ST_END   = 4'h8
  } smag_state_e;

endpackage

// ### testbench/smag_mem_model.sv
/*
  Behavioural model of the stacked static RAM and flash behind the host pins.
  Assumes the bench resolves the shared data lines and feeds them back on i_dq.
*/
`timescale 1ns/1ps
module smag_mem_model (
  // Shared pins
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_dq,
  // Static RAM pins
  input  wire logic        i_ssel_low_n,
  input  wire logic        i_ssel_high,
  input  wire logic        i_swe_n,
  input  wire logic        i_soe_n,
  // Flash pins
  input  wire logic        i_fsel_n,
  input  wire logic        i_fwe_n,
  input  wire logic        i_foe_n,
  input  wire logic        i_frp_n,
  input  wire logic        i_fhv,
  input  wire logic        i_fguard_n,
  input  wire logic        i_fvpp,
  // Data drive
  output logic      [15:0] o_dq,
  output logic             o_dq_oe
);
  logic [15:0] sram_r  [256];
  logic [15:0] flash_r [256];
  logic [7:0]  idx;
  logic        ssel;
  logic        swin;
  logic        fwin;
  logic        s_arm;
  logic        f_arm;
  assign idx  = {i_addr[19], i_addr[6:0]};
  assign ssel = !i_ssel_low_n && i_ssel_high;
  assign swin = ssel && !i_swe_n;
  assign fwin = !i_fsel_n && !i_fwe_n;
  initial begin
    s_arm = 1'b0;
    f_arm = 1'b0;
    foreach (flash_r[i]) flash_r[i] = 16'hffff;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Store when the overlap closes
  always @(swin) begin
    if (swin === 1'b0 && s_arm) sram_r[idx] = i_dq;
    s_arm = (swin === 1'b1);
  end
  // Top half of the space is boot; zeros clear bits, reprogrammed zeros corrupt the word
  always @(fwin) begin
    if (fwin === 1'b0 && f_arm && i_frp_n && i_fvpp && (!i_addr[19] || i_fguard_n || i_fhv)) begin
      if ((~flash_r[idx] & ~i_dq) != 16'h0) flash_r[idx] = 16'h0;
      else flash_r[idx] = flash_r[idx] & i_dq;
    end
    f_arm = (fwin === 1'b1);
  end
  always_comb begin
    o_dq_oe = 1'b0;
    o_dq    = 16'h0;
    if (ssel && !i_soe_n && i_swe_n) begin
      o_dq_oe = 1'b1;
      o_dq    = sram_r[idx];
    end else if (!i_fsel_n && !i_foe_n && i_frp_n) begin
      o_dq_oe = 1'b1;
      o_dq    = flash_r[idx];
    end
  end
endmodule

// ### testbench/tb_stacked_memory_access_guard.sv
/*
  Self-checking bench for the host controller against the memory model.
  Assumes the package latencies; undriven data lines show the inverse of the last value.
*/
`timescale 1ns/1ps
module tb_stacked_memory_access_guard;
  import smag_pkg::*;
  // Edges from the take edge to the one that raises done, per operation code
  localparam logic [15:0] LAT [4] = '{16'h6, 16'h5, 16'h6, 16'h4};
  logic        clk, rst_n, req, unlock, boot_lock, sup_ok, ready, done, oe, m_oe;
  logic        ssl_n, ssh, swe_n, soe_n, fsel_n, fwe_n, foe_n, frp_n, fhv, fg_n, fvpp;
  logic [1:0]  op;
  logic [19:0] addr, pa;
  logic [15:0] wd, old, rd, dout, din, m_dq, last;
  int          error_cnt, tests_run;
  smag_host_ctrl dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_op(op),
    .i_addr(addr), .i_wdata(wd), .i_old_data(old), .i_unlock_all(unlock),
    .i_boot_lock(boot_lock), .o_ready(ready), .o_done(done), .o_rdata(rd),
    .i_flash_supply_ok(sup_ok), .o_addr(pa), .i_data(din), .o_data(dout), .o_data_oe(oe),
    .o_sram_select_low_n(ssl_n), .o_sram_select_high(ssh), .o_sram_write_strobe_n(swe_n),
    .o_sram_output_gate_n(soe_n), .o_flash_select_n(fsel_n), .o_flash_write_strobe_n(fwe_n),
    .o_flash_output_gate_n(foe_n), .o_flash_reset_powerdown_n(frp_n),
    .o_flash_unlock_hv(fhv), .o_flash_boot_guard_n(fg_n), .o_program_supply_en(fvpp));
  smag_mem_model u_mem (.i_addr(pa), .i_dq(din), .i_ssel_low_n(ssl_n), .i_ssel_high(ssh),
    .i_swe_n(swe_n), .i_soe_n(soe_n), .i_fsel_n(fsel_n), .i_fwe_n(fwe_n), .i_foe_n(foe_n),
    .i_frp_n(frp_n), .i_fhv(fhv), .i_fguard_n(fg_n), .i_fvpp(fvpp), .o_dq(m_dq),
    .o_dq_oe(m_oe));
  assign din = oe ? dout : m_oe ? m_dq : ~last;
  initial clk = 1'b0;
  always #25 clk = ~clk;
  always @(posedge clk) last <= din;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic step(inout int n, input int lim);
    @(posedge clk);
    #1;
    n++;
    if (n > lim) begin
      chk("timeout", 16'h1, 16'h0);
      end_of_test;
    end
  endtask
  task automatic do_op(input logic [1:0] o, input logic [19:0] a, input logic [15:0] d,
                       input logic [15:0] od);
    int n;
    n = 0;
    while (ready !== 1'b1) step(n, 600);
    req  = 1'b1;
    op   = o;
    addr = a;
    wd   = d;
    old  = od;
    @(posedge clk);
    #1;
    req = 1'b0;
    n   = 0;
    while (done !== 1'b1) step(n, 20);
    chk("latency", 16'(n), LAT[o]);
  endtask
  // Both memories on the bus at once, or host fighting the memory
  always @(negedge clk) begin
    if (rst_n && ((!ssl_n && ssh && !fsel_n) || (oe && m_oe))) chk("overlap", 16'h1, 16'h0);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_sram;
    do_op(2'h1, 20'h00005, 16'ha5c3, 16'h0);
    do_op(2'h1, 20'h00006, 16'h5a3c, 16'h0);
    do_op(2'h0, 20'h00005, 16'h0, 16'h0);
    chk("sram_rd5", rd, 16'ha5c3);
    do_op(2'h0, 20'h00006, 16'h0, 16'h0);
    chk("sram_rd6", rd, 16'h5a3c);
    $display("test sram done");
  endtask
  task automatic t_flash;
    do_op(2'h3, 20'h00003, 16'h1234, 16'hffff);
    do_op(2'h2, 20'h00003, 16'h0, 16'h0);
    chk("flash_rd", rd, 16'h1234);
    do_op(2'h3, 20'h00003, 16'h1230, 16'h1234);
    do_op(2'h2, 20'h00003, 16'h0, 16'h0);
    chk("flash_reprog", rd, 16'h1230);
    $display("test flash done");
  endtask
  task automatic t_boot;
    boot_lock = 1'b1;
    do_op(2'h3, 20'h80001, 16'h00ff, 16'hffff);
    do_op(2'h2, 20'h80001, 16'h0, 16'h0);
    chk("boot_locked", rd, 16'hffff);
    do_op(2'h3, 20'h00001, 16'h00ff, 16'hffff);
    do_op(2'h2, 20'h00001, 16'h0, 16'h0);
    chk("main_open", rd, 16'h00ff);
    unlock = 1'b1;
    do_op(2'h3, 20'h80001, 16'h00ff, 16'hffff);
    do_op(2'h2, 20'h80001, 16'h0, 16'h0);
    chk("boot_unlock", rd, 16'h00ff);
    unlock    = 1'b0;
    boot_lock = 1'b0;
    $display("test boot done");
  endtask
  task automatic t_supply;
    int n;
    sup_ok = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("rp_drop", 16'(frp_n), 16'h0);
    chk("ready_drop", 16'(ready), 16'h0);
    sup_ok = 1'b1;
    for (n = 0; n < 3; n++) begin
      @(posedge clk);
      #1;
      chk("rp_hold", 16'(frp_n), 16'h0);
    end
    do_op(2'h2, 20'h00003, 16'h0, 16'h0);
    chk("flash_after", rd, 16'h1230);
    $display("test supply done");
  endtask
  initial begin
    rst_n     = 1'b0;
    req       = 1'b0;
    op        = 2'h0;
    addr      = 20'h0;
    wd        = 16'h0;
    old       = 16'h0;
    unlock    = 1'b0;
    boot_lock = 1'b0;
    sup_ok    = 1'b1;
    error_cnt = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    #1;
    chk("rp_reset", 16'(frp_n), 16'h0);
    rst_n = 1'b1;
    t_sram;
    t_flash;
    t_boot;
    t_supply;
    end_of_test;
  end
endmodule
